// ===== hw/sysreg_pkg.sv
// Shared types and constants for the system control and descriptor table registers
package sysreg_pkg;

  // ----------------------------------------------------------------
  // Mode control register bit positions
  // ----------------------------------------------------------------
  localparam int unsigned PROTECT_ENABLE_BIT = 0;
  localparam int unsigned WAIT_MONITOR_BIT = 1;
  localparam int unsigned FPU_TRAP_ALL_BIT = 2;
  localparam int unsigned TASK_SWITCHED_BIT = 3;
  localparam int unsigned RSVD_ONE_BIT = 4;
  localparam int unsigned RSVD_ZERO_LO_BIT = 5;
  localparam int unsigned WRITE_PROTECT_BIT = 16;
  localparam int unsigned ALIGNMENT_MASK_BIT = 18;
  localparam int unsigned RSVD_ZERO_HI_BIT = 29;
  localparam int unsigned CACHE_DISABLE_BIT = 30;
  localparam int unsigned PAGING_ON_BIT = 31;

  // Bits software may change; everything else is held at its fixed value
  localparam logic [31:0] MODE_WRITE_MASK = 32'hC005_000F;
  // Fixed bits: bit 4 reads one, bits 5 and 29 and all unlisted bits read zero
  localparam logic [31:0] MODE_FIXED_VALUE = 32'h0000_0010;
  localparam logic [31:0] MODE_RESET = 32'h0000_0010;

  // ----------------------------------------------------------------
  // Other reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [31:0] FAULT_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] PAGE_DIR_MASK = 32'hFFFF_F000;
  localparam logic [31:0] PAGE_DIR_RESET = 32'h0000_0000;
  localparam logic [47:0] TABLE_PTR_RESET = 48'h0000_0000_FFFF;
  localparam logic [15:0] SELECTOR_RESET = 16'h0000;
  localparam logic [31:0] BASE16_MASK = 32'h00FF_FFFF;
  localparam int unsigned SEL_TABLE_SELECT_BIT = 2;
  localparam logic [3:0] SYS_TYPE_LOCAL_TABLE = 4'h2;
  localparam logic [3:0] SYS_TYPE_TASK_IDLE = 4'h9;
  localparam logic [3:0] SYS_TYPE_TASK_BUSY = 4'hB;
  localparam logic [1:0] PRIV_LEVEL_TOP = 2'h0;
  localparam logic [1:0] PRIV_LEVEL_USER = 2'h3;

  // ----------------------------------------------------------------
  // System register load and store operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_WR_MODE, OP_RD_MODE, OP_WR_FAULT_ADDR, OP_RD_FAULT_ADDR,
    OP_WR_PAGE_DIR, OP_RD_PAGE_DIR, OP_LOAD_GLOBAL, OP_STORE_GLOBAL,
    OP_LOAD_VECTOR, OP_STORE_VECTOR, OP_LOAD_LOCAL, OP_STORE_LOCAL
  } op_t;

  // One command from the instruction unit
  typedef struct packed {
    logic valid;
    op_t op;
    logic [47:0] data;
    logic op32;
    logic [1:0] cpl;
  } cmd_t;

  // Answer to a command
  typedef struct packed {
    logic valid;
    logic fault;
    logic [47:0] data;
  } rsp_t;

  // Decoded segment descriptor
  typedef struct packed {
    logic [31:0] base;
    logic [19:0] limit;
    logic gran_4k;
    logic size32;
    logic avail;
    logic present;
    logic [1:0] priv;
    logic app;
    logic [3:0] kind;
  } desc_t;

  // Segment register load request and its answer
  typedef struct packed {
    logic valid;
    logic [15:0] selector;
    logic [63:0] desc;
  } seg_req_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [31:0] desc_addr;
    desc_t desc;
  } seg_rsp_t;

endpackage

// ===== hw/system_control_regs.sv
// System mode control, fault address, page directory and descriptor table registers
`timescale 1ns/1ns

// Functional notes
// RQ1: Bit 0 set selects protected mode
// RQ2: Wait-monitor plus task-switched makes WAIT fault 7
// RQ3: Emulate bit makes every float op fault 7
// RQ4: Task switch sets bit 3; float then faults
// RQ5: Bit 4 reads one, bits 5,29 zero
// RQ6: Write-protect faults read-only writes at all levels
// RQ7: Alignment mask gates every alignment check fault
// RQ8: Cache disable stops fills, hits still served
// RQ9: Paging needs both paging and protect bits
// RQ10: Page fault captures full linear address
// RQ11: Page directory keeps 20-bit base, low 12 zero
// RQ12: Protected mode: writes only from level 0
// RQ13: Global pointer holds 32-bit base, 16-bit limit
// RQ14: Sixteen-bit global load keeps 24-bit base
// RQ15: Vector pointer holds 32-bit base, 16-bit limit
// RQ16: Table loads privileged; local selector protected only
// RQ17: Local selector load fetches and caches descriptor
// RQ18: Table-select bit picks global or local table
// RQ19: System descriptors live only in global table
// RQ20: Descriptor base and limit assembled from fields
// RQ21: Bit 23 granularity, bit 22 default size
// RQ22: Bit 12 class; system types 0010,1001,1011
// RQ23: Flags alignment check needs mask bit set
// RQ24: Stores return exactly the last loaded values
module system_control_regs (
  input wire logic mclk,
  input wire logic reset_n,
  input sysreg_pkg::cmd_t cmd,
  output sysreg_pkg::rsp_t rsp,
  output logic busy,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic fetch_ack,
  input wire logic [63:0] fetch_data,
  input wire logic task_switch,
  input wire logic page_fault,
  input wire logic [31:0] page_fault_addr,
  input wire logic fpu_op,
  input wire logic wait_op,
  input wire logic misaligned,
  input wire logic align_check_flag,
  input wire logic ro_page_write,
  input wire logic [1:0] cur_priv,
  input sysreg_pkg::seg_req_t seg_req,
  output sysreg_pkg::seg_rsp_t seg_rsp,
  output logic [31:0] mode_control,
  output logic [31:0] page_dir_base,
  output logic protect_mode,
  output logic paging_active,
  output logic cache_fill_en,
  output logic fpu_unavailable_fault,
  output logic align_fault,
  output logic write_protect_fault,
  output sysreg_pkg::desc_t local_table_desc,
  output logic local_table_valid
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Splits an eight-byte descriptor into its fields
  function automatic sysreg_pkg::desc_t decode_desc(input logic [63:0] d);
    sysreg_pkg::desc_t r;
    r.base = {d[63:56], d[39:32], d[31:16]}; // RQ20
    r.limit = {d[51:48], d[15:0]}; // RQ20
    r.gran_4k = d[55]; // RQ21
    r.size32 = d[54]; // RQ21
    r.avail = d[52];
    r.present = d[47];
    r.priv = d[46:45];
    r.app = d[44]; // RQ22
    r.kind = d[43:40]; // RQ22
    return r;
  endfunction

  // Byte address of a selector's descriptor within a table
  function automatic logic [31:0] entry_addr(input logic [31:0] base, input logic [15:0] sel);
    return base + {16'h0000, sel[15:3], 3'b000};
  endfunction

  // True when the whole eight-byte entry lies inside the table limit
  function automatic logic entry_in_limit(input logic [15:0] limit, input logic [15:0] sel);
    return {sel[15:3], 3'b111} <= limit;
  endfunction

  // ----------------------------------------------------------------
  // Register file and local descriptor fetch
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_FETCH} fetch_state_t;

  fetch_state_t state_ff, nxt_state; // Fetch sequencer
  logic [31:0] mode_ff, nxt_mode; // Mode control register
  logic [31:0] fault_addr_ff, nxt_fault_addr; // Faulting linear address
  logic [31:0] pdb_ff, nxt_pdb; // Page directory base
  logic [47:0] gtp_ff, nxt_gtp; // Global table pointer: base high, limit low
  logic [47:0] vtp_ff, nxt_vtp; // Vector table pointer
  logic [15:0] lts_ff, nxt_lts; // Local table selector
  logic [15:0] pend_sel_ff, nxt_pend_sel; // Selector awaiting its descriptor
  sysreg_pkg::desc_t ldesc_ff, nxt_ldesc; // Hidden cached local descriptor
  logic ldesc_valid_ff, nxt_ldesc_valid; // Hidden part holds a real table
  sysreg_pkg::rsp_t rsp_ff, nxt_rsp; // Command answer
  logic fetch_req_ff, nxt_fetch_req; // Descriptor read request
  logic [31:0] fetch_addr_ff, nxt_fetch_addr; // Descriptor read address

  logic pe_now; // Protected mode as currently held
  logic priv_ok; // Writer allowed to modify system state
  sysreg_pkg::desc_t fetched; // Returned descriptor, decoded

  assign pe_now = mode_ff[sysreg_pkg::PROTECT_ENABLE_BIT];
  // Real mode has no privilege check at all
  assign priv_ok = !pe_now || (cmd.cpl == sysreg_pkg::PRIV_LEVEL_TOP); // RQ12 RQ16
  assign fetched = decode_desc(fetch_data);

  // Next values of the register file
  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_fault_addr = fault_addr_ff;
    nxt_pdb = pdb_ff;
    nxt_gtp = gtp_ff;
    nxt_vtp = vtp_ff;
    nxt_lts = lts_ff;
    nxt_pend_sel = pend_sel_ff;
    nxt_ldesc = ldesc_ff;
    nxt_ldesc_valid = ldesc_valid_ff;
    nxt_fetch_req = fetch_req_ff;
    nxt_fetch_addr = fetch_addr_ff;
    nxt_rsp = '{valid: 1'b0, fault: 1'b0, data: rsp_ff.data};
    unique case (state_ff)
      ST_IDLE: begin
        // Commands are taken only while no fetch is outstanding
        if (cmd.valid) begin
          nxt_rsp.valid = 1'b1;
          unique case (cmd.op)
            sysreg_pkg::OP_WR_MODE: begin
              // Reserved bits keep their fixed values whatever is written
              nxt_rsp.fault = !priv_ok; // RQ12
              if (priv_ok) nxt_mode = (cmd.data[31:0] & sysreg_pkg::MODE_WRITE_MASK)
                                    | sysreg_pkg::MODE_FIXED_VALUE; // RQ5
            end
            sysreg_pkg::OP_RD_MODE: nxt_rsp.data = {16'h0000, mode_ff};
            sysreg_pkg::OP_WR_FAULT_ADDR: begin
              nxt_rsp.fault = !priv_ok; // RQ12
              if (priv_ok) nxt_fault_addr = cmd.data[31:0];
            end
            sysreg_pkg::OP_RD_FAULT_ADDR: nxt_rsp.data = {16'h0000, fault_addr_ff};
            sysreg_pkg::OP_WR_PAGE_DIR: begin
              nxt_rsp.fault = !priv_ok; // RQ12
              if (priv_ok) nxt_pdb = cmd.data[31:0] & sysreg_pkg::PAGE_DIR_MASK; // RQ11
            end
            sysreg_pkg::OP_RD_PAGE_DIR: nxt_rsp.data = {16'h0000, pdb_ff};
            sysreg_pkg::OP_LOAD_GLOBAL: begin
              nxt_rsp.fault = !priv_ok; // RQ16
              if (priv_ok) nxt_gtp = cmd.data; // RQ13
              // Short operand size drops the top byte of the base
              if (priv_ok && !cmd.op32)
                nxt_gtp[47:16] = cmd.data[47:16] & sysreg_pkg::BASE16_MASK; // RQ14
            end
            sysreg_pkg::OP_STORE_GLOBAL: nxt_rsp.data = gtp_ff; // RQ13 RQ24
            sysreg_pkg::OP_LOAD_VECTOR: begin
              nxt_rsp.fault = !priv_ok; // RQ16
              if (priv_ok) nxt_vtp = cmd.data; // RQ15
              if (priv_ok && !cmd.op32)
                nxt_vtp[47:16] = cmd.data[47:16] & sysreg_pkg::BASE16_MASK;
            end
            sysreg_pkg::OP_STORE_VECTOR: nxt_rsp.data = vtp_ff; // RQ15 RQ24
            sysreg_pkg::OP_LOAD_LOCAL: begin
              if (!pe_now || !priv_ok) begin // RQ16
                nxt_rsp.fault = 1'b1;
              end else if (cmd.data[15:3] == 13'h0000) begin
                // Null selector: nothing to fetch, table marked unusable
                nxt_lts = cmd.data[15:0];
                nxt_ldesc_valid = 1'b0;
              end else if (cmd.data[sysreg_pkg::SEL_TABLE_SELECT_BIT]
                           || !entry_in_limit(gtp_ff[15:0], cmd.data[15:0])) begin
                // The local table descriptor must come from the global table
                nxt_rsp.fault = 1'b1; // RQ19
              end else begin
                // Answer is deferred until the descriptor arrives
                nxt_rsp.valid = 1'b0;
                nxt_pend_sel = cmd.data[15:0];
                nxt_fetch_req = 1'b1; // RQ17
                nxt_fetch_addr = entry_addr(gtp_ff[47:16], cmd.data[15:0]);
                nxt_state = ST_FETCH;
              end
            end
            sysreg_pkg::OP_STORE_LOCAL: begin
              nxt_rsp.fault = !pe_now; // RQ16
              if (pe_now) nxt_rsp.data = {32'h0000_0000, lts_ff}; // RQ24
            end
            default: nxt_rsp.fault = 1'b1; // Undefined operation code
          endcase
        end
      end
      ST_FETCH: begin
        // The cached copy changes only here, never from a later table edit
        if (fetch_ack) begin // RQ17
          nxt_fetch_req = 1'b0;
          nxt_state = ST_IDLE;
          nxt_rsp.valid = 1'b1;
          if (!fetched.app && fetched.present
              && fetched.kind == sysreg_pkg::SYS_TYPE_LOCAL_TABLE) begin // RQ22
            nxt_lts = pend_sel_ff;
            nxt_ldesc = fetched;
            nxt_ldesc_valid = 1'b1;
          end else begin
            // Wrong kind or absent: the old selector and cache are kept
            nxt_rsp.fault = 1'b1;
          end
        end
      end
    endcase
    // Hardware capture wins over a software write in the same cycle
    if (page_fault && mode_ff[sysreg_pkg::PAGING_ON_BIT] && pe_now)
      nxt_fault_addr = page_fault_addr; // RQ10
    // Task switch set wins over a clear written in the same cycle
    if (task_switch) nxt_mode[sysreg_pkg::TASK_SWITCHED_BIT] = 1'b1; // RQ4
  end

  // Register file flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      mode_ff <= sysreg_pkg::MODE_RESET; // RQ5
      fault_addr_ff <= sysreg_pkg::FAULT_ADDR_RESET;
      pdb_ff <= sysreg_pkg::PAGE_DIR_RESET;
      gtp_ff <= sysreg_pkg::TABLE_PTR_RESET;
      vtp_ff <= sysreg_pkg::TABLE_PTR_RESET;
      lts_ff <= sysreg_pkg::SELECTOR_RESET;
      pend_sel_ff <= sysreg_pkg::SELECTOR_RESET;
      ldesc_ff <= '0;
      ldesc_valid_ff <= 1'b0;
      rsp_ff <= '0;
      fetch_req_ff <= 1'b0;
      fetch_addr_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      fault_addr_ff <= nxt_fault_addr;
      pdb_ff <= nxt_pdb;
      gtp_ff <= nxt_gtp;
      vtp_ff <= nxt_vtp;
      lts_ff <= nxt_lts;
      pend_sel_ff <= nxt_pend_sel;
      ldesc_ff <= nxt_ldesc;
      ldesc_valid_ff <= nxt_ldesc_valid;
      rsp_ff <= nxt_rsp;
      fetch_req_ff <= nxt_fetch_req;
      fetch_addr_ff <= nxt_fetch_addr;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and fault checks
  // ----------------------------------------------------------------
  logic pe_ff, nxt_pe; // Protected mode flag
  logic pg_ff, nxt_pg; // Paging in force
  logic fill_ff, nxt_fill; // Cache may allocate lines
  logic fpu_flt_ff, nxt_fpu_flt; // Fault 7 pulse
  logic align_flt_ff, nxt_align_flt; // Alignment fault pulse
  logic wp_flt_ff, nxt_wp_flt; // Read-only page write fault pulse

  // Checks use the mode as held, so a write takes effect from the next cycle
  always_comb begin
    nxt_pe = mode_ff[sysreg_pkg::PROTECT_ENABLE_BIT]; // RQ1
    nxt_pg = mode_ff[sysreg_pkg::PAGING_ON_BIT]
           && mode_ff[sysreg_pkg::PROTECT_ENABLE_BIT]; // RQ9
    // Hits are still served when fills stop; invalidation is the cache's job
    nxt_fill = !mode_ff[sysreg_pkg::CACHE_DISABLE_BIT]; // RQ8
    nxt_fpu_flt = (fpu_op && (mode_ff[sysreg_pkg::FPU_TRAP_ALL_BIT]
                              || mode_ff[sysreg_pkg::TASK_SWITCHED_BIT])) // RQ3 RQ4
                || (wait_op && mode_ff[sysreg_pkg::WAIT_MONITOR_BIT]
                    && mode_ff[sysreg_pkg::TASK_SWITCHED_BIT]); // RQ2
    nxt_align_flt = misaligned && align_check_flag
                  && mode_ff[sysreg_pkg::ALIGNMENT_MASK_BIT]; // RQ7 RQ23
    // Supervisor levels 0 to 2 pass unless write-protect is on
    nxt_wp_flt = ro_page_write && (mode_ff[sysreg_pkg::WRITE_PROTECT_BIT]
                                   || cur_priv == sysreg_pkg::PRIV_LEVEL_USER); // RQ6
  end

  // Fault check flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pe_ff <= 1'b0;
      pg_ff <= 1'b0;
      fill_ff <= 1'b1;
      fpu_flt_ff <= 1'b0;
      align_flt_ff <= 1'b0;
      wp_flt_ff <= 1'b0;
    end else begin
      pe_ff <= nxt_pe;
      pg_ff <= nxt_pg;
      fill_ff <= nxt_fill;
      fpu_flt_ff <= nxt_fpu_flt;
      align_flt_ff <= nxt_align_flt;
      wp_flt_ff <= nxt_wp_flt;
    end
  end

  // ----------------------------------------------------------------
  // Segment register load decode
  // ----------------------------------------------------------------
  sysreg_pkg::seg_rsp_t seg_ff, nxt_seg; // Decoded segment answer
  logic seg_local; // Selector points into the local table

  assign seg_local = seg_req.selector[sysreg_pkg::SEL_TABLE_SELECT_BIT];

  // Locates and decodes the descriptor for a segment register load
  always_comb begin
    nxt_seg.valid = seg_req.valid;
    nxt_seg.desc = decode_desc(seg_req.desc);
    nxt_seg.desc_addr = seg_local ? entry_addr(ldesc_ff.base, seg_req.selector)
                                  : entry_addr(gtp_ff[47:16], seg_req.selector); // RQ18
    // Local lookups need a loaded table; system kinds may not sit there
    nxt_seg.fault = seg_req.valid && seg_local
                  && (!ldesc_valid_ff || !nxt_seg.desc.app); // RQ19
  end

  // Segment decode flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      seg_ff <= '0;
    end else begin
      seg_ff <= nxt_seg;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign rsp = rsp_ff;
  assign busy = (state_ff == ST_FETCH);
  assign fetch_req = fetch_req_ff;
  assign fetch_addr = fetch_addr_ff;
  assign seg_rsp = seg_ff;
  assign mode_control = mode_ff;
  assign page_dir_base = pdb_ff;
  assign protect_mode = pe_ff;
  assign paging_active = pg_ff;
  assign cache_fill_en = fill_ff;
  assign fpu_unavailable_fault = fpu_flt_ff;
  assign align_fault = align_flt_ff;
  assign write_protect_fault = wp_flt_ff;
  assign local_table_desc = ldesc_ff;
  assign local_table_valid = ldesc_valid_ff;

endmodule // system_control_regs

// ===== bench/system_control_checker.sv
// Concurrent checks on the ports of the system control register block
`timescale 1ns/1ns
module system_control_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input sysreg_pkg::rsp_t rsp,
  input wire logic fetch_req,
  input wire logic fetch_ack,
  input wire logic task_switch,
  input wire logic fpu_op,
  input wire logic wait_op,
  input wire logic misaligned,
  input wire logic align_check_flag,
  input wire logic ro_page_write,
  input wire logic [1:0] cur_priv,
  input wire logic [31:0] mode_control,
  input wire logic [31:0] page_dir_base,
  input wire logic paging_active,
  input wire logic cache_fill_en,
  input wire logic fpu_unavailable_fault,
  input wire logic align_fault,
  input wire logic write_protect_fault
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Fault causes as sampled at one edge, judged against the next
  wire logic fpu_cause = fpu_op & (mode_control[2] | mode_control[3])
    | wait_op & mode_control[1] & mode_control[3];
  wire logic align_cause = misaligned & align_check_flag & mode_control[18];
  // Descriptor fetch completes, then the command answers on the next cycle
  sequence fetch_taken;
    fetch_req && fetch_ack;
  endsequence
  sequence local_answer;
    !fetch_req && rsp.valid;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_FPU_FAULT: assert property (##1 fpu_unavailable_fault == $past(fpu_cause))
    else $error("device fault pulse wrong");
  AST_ALIGN_NEVER: assert property (!mode_control[18] |=> !align_fault)
    else $error("alignment fault while masked");
  AST_ALIGN_FIRE: assert property (align_cause |=> align_fault)
    else $error("alignment fault missing");
  AST_WP_FAULT: assert property (##1 write_protect_fault ==
    $past(ro_page_write & (mode_control[16] | cur_priv == 2'h3)))
    else $error("write protect fault wrong");
  AST_RSVD_BITS: assert property ((mode_control & ~sysreg_pkg::MODE_WRITE_MASK) ==
    sysreg_pkg::MODE_FIXED_VALUE)
    else $error("fixed mode bits changed");
  AST_PAGING: assert property (##1 paging_active == $past(mode_control[31] & mode_control[0]))
    else $error("paging state wrong");
  AST_CACHE: assert property ($changed(mode_control[30]) |=> cache_fill_en == !$past(mode_control[30]))
    else $error("cache fill enable wrong");
  AST_TASK_SWITCH: assert property (task_switch |=> mode_control[3])
    else $error("task switched bit not set");
  AST_PAGE_DIR: assert property (page_dir_base[11:0] == 12'h000)
    else $error("page directory low bits set");
  AST_FETCH_ANSWER: assert property (fetch_taken |=> local_answer)
    else $error("local load answer missing");
endmodule // system_control_checker

// ===== bench/testbench.sv
// Self-checking bench for the system control register block
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench;
  // ----------------------------------------------------------------
  // Signals and helpers
  // ----------------------------------------------------------------
  localparam logic [63:0] GOOD = 64'h12C0_8234_5678_FFFF; // Local table entry
  localparam logic [63:0] BAD = 64'h0040_9200_0000_FFFF; // Application entry
  logic mclk, reset_n, busy, fetch_req, fetch_ack, task_switch, page_fault, fpu_op, wait_op;
  logic misaligned, align_check_flag, ro_page_write, protect_mode, paging_active;
  logic cache_fill_en, fpu_unavailable_fault, align_fault, write_protect_fault;
  logic local_table_valid;
  logic [1:0] cur_priv;
  logic [31:0] fetch_addr, page_fault_addr, mode_control, page_dir_base, st, mexp, gb, fa, a;
  logic [63:0] fetch_data, d;
  logic [47:0] ptr;
  logic [15:0] s;
  sysreg_pkg::op_t lo;
  sysreg_pkg::cmd_t cmd;
  sysreg_pkg::rsp_t rsp;
  sysreg_pkg::seg_req_t seg_req;
  sysreg_pkg::seg_rsp_t seg_rsp;
  sysreg_pkg::desc_t local_table_desc;
  int bad_count, samples_checked, nf;
  system_control_regs DUT (.mclk, .reset_n, .cmd, .rsp, .busy, .fetch_req, .fetch_addr,
    .fetch_ack, .fetch_data, .task_switch, .page_fault, .page_fault_addr, .fpu_op, .wait_op,
    .misaligned, .align_check_flag, .ro_page_write, .cur_priv, .seg_req, .seg_rsp,
    .mode_control, .page_dir_base, .protect_mode, .paging_active, .cache_fill_en,
    .fpu_unavailable_fault, .align_fault, .write_protect_fault, .local_table_desc,
    .local_table_valid);
  // Xorshift source, fixed seed
  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  // Expected decode of a raw descriptor
  function automatic sysreg_pkg::desc_t dec(logic [63:0] x);
    return '{{x[63:56], x[39:32], x[31:16]}, {x[51:48], x[15:0]}, x[55], x[54], x[52],
      x[47], x[46:45], x[44], x[43:40]};
  endfunction
  // One command, waiting a bounded time for its answer
  task automatic send(sysreg_pkg::op_t op, logic [47:0] v, logic w, logic [1:0] p, logic f);
    @(posedge mclk) cmd <= '{1'b1, op, v, w, p};
    @(posedge mclk) cmd.valid <= 1'b0;
    #1;
    for (int i = 0; i < 40 && rsp.valid !== 1'b1; i++) @(posedge mclk) #1;
    `CHK(rsp.valid, 1'b1)
    `CHK(rsp.fault, f)
  endtask
  // Mode write; refused above level 0 once protected
  task automatic wmode(logic [31:0] v, logic [1:0] p);
    logic ok;
    ok = !mexp[0] || p == 2'h0;
    send(sysreg_pkg::OP_WR_MODE, {16'h0, v}, 1'b1, p, !ok);
    if (ok) mexp = (v & sysreg_pkg::MODE_WRITE_MASK) | sysreg_pkg::MODE_FIXED_VALUE;
    `CHK(mode_control, mexp)
    @(posedge mclk);
    #1 `CHK(protect_mode, mexp[0])
    `CHK(paging_active, mexp[31] & mexp[0])
    `CHK(cache_fill_en, !mexp[30])
  endtask
  // Random access conditions, faults judged one cycle later
  task automatic evs();
    logic [4:0] r;
    logic [1:0] p;
    r = 5'(rnd());
    p = 2'(rnd());
    @(posedge mclk) {fpu_op, wait_op, misaligned, align_check_flag, ro_page_write} <= r;
    cur_priv <= p;
    @(posedge mclk);
    #1 `CHK(fpu_unavailable_fault, r[4] & (mexp[2] | mexp[3]) | r[3] & mexp[1] & mexp[3])
    `CHK(align_fault, r[2] & r[1] & mexp[18])
    `CHK(write_protect_fault, r[0] & (mexp[16] | p == 2'h3))
  endtask
  // Page fault pulse, then the captured address read back
  task automatic pf(logic [31:0] v, logic [31:0] e);
    @(posedge mclk) page_fault <= 1'b1;
    page_fault_addr <= v;
    @(posedge mclk) page_fault <= 1'b0;
    send(sysreg_pkg::OP_RD_FAULT_ADDR, 48'h0, 1'b1, 2'h0, 1'b0);
    `CHK(rsp.data, {16'h0, e})
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and descriptor memory
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    close_out();
  end
  // Answers fetches after a random stall; only entry 1 is a local table
  always @(posedge mclk) begin
    if (fetch_req && fetch_ack) begin
      nf++;
      `CHK(fetch_addr, fa)
      `CHK(busy, 1'b1)
    end
    fetch_ack <= fetch_req && !fetch_ack && (rnd() & 32'h3) == 32'h0;
    fetch_data <= (fa == gb + 32'h8) ? GOOD : BAD;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    st = 32'hE36F_8AD1;
    {bad_count, samples_checked, nf} = '0;
    mexp = sysreg_pkg::MODE_RESET;
    {reset_n, task_switch, page_fault, fpu_op, wait_op, misaligned} = '0;
    {align_check_flag, ro_page_write, cur_priv, page_fault_addr, gb, fa} = '0;
    cmd = '0;
    seg_req = '0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    `CHK(mode_control, sysreg_pkg::MODE_RESET)
    send(sysreg_pkg::OP_STORE_GLOBAL, 48'h0, 1'b1, 2'h0, 1'b0);
    `CHK(rsp.data, sysreg_pkg::TABLE_PTR_RESET)
    wmode(32'h8000_0000, 2'h0);
    wmode(32'hFFFF_FFFF, 2'h0);
    repeat (4) evs();
    wmode(32'h0, 2'h3);
    for (int i = 0; i < 12; i++) begin
      wmode(rnd(), 2'(rnd()));
      repeat (3) evs();
    end
    wmode(32'h0000_0002, 2'h0);
    @(posedge mclk) task_switch <= 1'b1;
    @(posedge mclk) task_switch <= 1'b0;
    mexp[3] = 1'b1;
    #1 `CHK(mode_control[3], 1'b1)
    repeat (4) evs();
    $display("mode tests done");
    wmode(32'h8000_0001, 2'h0);
    a = rnd();
    pf(a, a);
    wmode(32'h0000_0001, 2'h0);
    pf(~a, a);
    d = {32'h0, rnd()};
    send(sysreg_pkg::OP_WR_PAGE_DIR, d[47:0], 1'b1, 2'h0, 1'b0);
    send(sysreg_pkg::OP_WR_PAGE_DIR, ~d[47:0], 1'b1, 2'h3, 1'b1);
    send(sysreg_pkg::OP_RD_PAGE_DIR, 48'h0, 1'b1, 2'h1, 1'b0);
    `CHK(rsp.data, {16'h0, d[31:0] & sysreg_pkg::PAGE_DIR_MASK})
    for (int k = 0; k < 4; k++) begin
      ptr = {rnd(), 16'(rnd()) | 16'h00FF};
      lo = k[1] ? sysreg_pkg::OP_LOAD_VECTOR : sysreg_pkg::OP_LOAD_GLOBAL;
      send(lo, ptr, k[0], 2'h3, 1'b1);
      send(lo, ptr, k[0], 2'h0, 1'b0);
      if (!k[0]) ptr[47:40] = 8'h00;
      if (k == 1) gb = ptr[47:16];
      send(sysreg_pkg::op_t'(lo + 1), 48'h0, 1'b1, 2'h0, 1'b0);
      `CHK(rsp.data, ptr)
    end
    $display("pointer tests done");
    wmode(32'h0, 2'h0);
    send(sysreg_pkg::OP_LOAD_LOCAL, 48'h8, 1'b1, 2'h0, 1'b1);
    wmode(32'h0000_0001, 2'h0);
    fa = gb + 32'h8;
    send(sysreg_pkg::OP_LOAD_LOCAL, 48'h8, 1'b1, 2'h0, 1'b0);
    `CHK(local_table_valid, 1'b1)
    `CHK(local_table_desc, dec(GOOD))
    fa = gb + 32'h10;
    send(sysreg_pkg::OP_LOAD_LOCAL, 48'h10, 1'b1, 2'h0, 1'b1);
    send(sysreg_pkg::OP_STORE_LOCAL, 48'h0, 1'b1, 2'h3, 1'b0);
    `CHK(rsp.data, 48'h8)
    for (int i = 0; i < 12; i++) begin
      s = 16'(rnd());
      d = {rnd(), rnd()};
      if (i < 3) d[44:40] = {1'b0, i == 0 ? 4'h2 : i == 1 ? 4'h9 : 4'hB};
      @(posedge mclk) seg_req <= '{1'b1, s, d};
      @(posedge mclk) seg_req.valid <= 1'b0;
      #1 `CHK(seg_rsp.valid, 1'b1)
      `CHK(seg_rsp.desc, dec(d))
      `CHK(seg_rsp.desc_addr, (s[2] ? 32'h1234_5678 : gb) + {s[15:3], 3'h0})
      `CHK(seg_rsp.fault, s[2] & !d[44])
    end
    `CHK(nf, 2)
    $display("descriptor tests done");
    close_out();
  end
endmodule // testbench
bind system_control_regs system_control_checker chk (.mclk, .reset_n, .rsp, .fetch_req,
  .fetch_ack, .task_switch, .fpu_op, .wait_op, .misaligned, .align_check_flag, .ro_page_write,
  .cur_priv, .mode_control, .page_dir_base, .paging_active, .cache_fill_en,
  .fpu_unavailable_fault, .align_fault, .write_protect_fault);
